// ===== hvsl_params.svh
// Offsets, field positions, reset values and sizes for the serial output latch.
`ifndef HVSL_PARAMS_SVH
`define HVSL_PARAMS_SVH
`define HVSL_WORD_W 24
`define HVSL_OUT_W 21
`define HVSL_CNT_W 5
`define HVSL_BITS_PER_WORD 5'h18
`define HVSL_CNT_MAX 5'h1F
`define HVSL_SELECT_BIT 0
`define HVSL_OUTPUT_SELECT_BITS_LSB 1
`define HVSL_OUTPUT_SELECT_BITS_MSB 21
`define HVSL_VSEL_LSB 1
`define HVSL_VSEL_MSB 3
`define HVSL_CAP_LSB 4
`define HVSL_CAP_MSB 5
`define HVSL_SSOFF_BIT 6
`define HVSL_SYNC_BIT 7
`define HVSL_CAPDIS_BIT 8
`define HVSL_ADR_W 4
`define HVSL_ADR_CTRL 2'h0
`define HVSL_ADR_CFG 2'h1
`define HVSL_ADR_DATA 2'h2
`define HVSL_ADR_STAT 2'h3
`define HVSL_CTRL_ALLOW_BIT 0
`define HVSL_CTRL_RESET 1'h1
`define HVSL_STAT_ERR_BIT 0
`define HVSL_STAT_CNT_LSB 8
`define HVSL_WORD_RESET 24'h00_0000
`define HVSL_SYNC_RESET 4'h4
`define HVSL_LE_IDLE 1'b1
`define HVSL_OUT_RESET 21'h00_0000
`endif

// ===== hvsl_pkg.sv
// Types shared by the serial output latch.
package hvsl_pkg;
    typedef logic [23:0] hvsl_word_type;
    typedef logic [20:0] hvsl_out_type;
    typedef logic [4:0] hvsl_cnt_type;
endpackage

// ===== hvsl_serial_latch.sv
// Serial shift-and-latch front end with a Wishbone register window.
`timescale 1ns/1ps
`include "hvsl_params.svh"

// Operation
// - Data changes while clock low; device samples on clock rise.
// - Strobe rise copies the shifted word into its register.
// - Gate asserted with the control allow bit set drives selected outputs high, others low.
// - Gate deasserted forces every output-select bit low; configuration outputs keep their values.
// - Boost target comes from the three-bit voltage select field.
// - Word bit 0 routes to configuration (0) or data (1).
// - Data bits 21..1 select outputs; bits 23..22 read zero.
module hvsl_serial_latch (
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    input wire logic i_link_clk,
    input wire logic i_link_din,
    input wire logic i_latch_strobe,
    input wire logic i_output_gate,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [`HVSL_ADR_W-1:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    output logic [`HVSL_OUT_W-1:0] o_output_select_bits,
    output logic [2:0] o_boost_vsel,
    output logic [1:0] o_current_cap_field,
    output logic o_current_cap_disable,
    output logic o_sync_enable,
    output logic o_soft_start_off
);

    // ---------------------------------------------------------------
    // Pin synchronisers
    // ---------------------------------------------------------------
    // All four pins share one two-stage path so their edges stay aligned.
    logic [3:0] sync1_r;
    logic [3:0] sync2_r;
    logic [3:0] sync1_nxt;
    logic [3:0] sync2_nxt;
    logic sclk_d_r;
    logic le_d_r;
    logic sclk_d_nxt;
    logic le_d_nxt;
    logic sclk_s;
    logic din_s;
    logic le_s;
    logic gate_s;
    logic sclk_rise;
    logic le_rise;
    logic le_fall;

    always_comb begin
        sync1_nxt = {i_output_gate, i_latch_strobe, i_link_din, i_link_clk};
        sync2_nxt = sync1_r;
        sclk_d_nxt = sync2_r[0];
        le_d_nxt = sync2_r[2];
    end

    // The strobe idles high, so its stages reset high: a low reset value would
    // fake a strobe rise just after reset and flag a bad frame that never was.
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            sync1_r <= `HVSL_SYNC_RESET;
            sync2_r <= `HVSL_SYNC_RESET;
            sclk_d_r <= 1'b0;
            le_d_r <= `HVSL_LE_IDLE;
        end else begin
            sync1_r <= sync1_nxt;
            sync2_r <= sync2_nxt;
            sclk_d_r <= sclk_d_nxt;
            le_d_r <= le_d_nxt;
        end
    end

    assign sclk_s = sync2_r[0];
    assign din_s = sync2_r[1];
    assign le_s = sync2_r[2];
    assign gate_s = sync2_r[3];
    assign sclk_rise = sclk_s & ~sclk_d_r;
    assign le_rise = le_s & ~le_d_r;
    assign le_fall = ~le_s & le_d_r;

    // ---------------------------------------------------------------
    // Shift path and latches
    // ---------------------------------------------------------------
    hvsl_pkg::hvsl_word_type shift_r;
    hvsl_pkg::hvsl_word_type shift_nxt;
    hvsl_pkg::hvsl_word_type cfg_r;
    hvsl_pkg::hvsl_word_type cfg_nxt;
    hvsl_pkg::hvsl_out_type dat_r;
    hvsl_pkg::hvsl_out_type dat_nxt;
    hvsl_pkg::hvsl_cnt_type cnt_r;
    hvsl_pkg::hvsl_cnt_type cnt_nxt;
    hvsl_pkg::hvsl_cnt_type last_cnt_r;
    hvsl_pkg::hvsl_cnt_type last_cnt_nxt;

    always_comb begin
        shift_nxt = shift_r;
        cnt_nxt = cnt_r;
        cfg_nxt = cfg_r;
        dat_nxt = dat_r;
        last_cnt_nxt = last_cnt_r;
        if (le_fall) begin
            cnt_nxt = '0;
        end
        if (!le_s && sclk_rise) begin
            shift_nxt = {shift_r[`HVSL_WORD_W-2:0], din_s};
            if (cnt_r != `HVSL_CNT_MAX) begin
                cnt_nxt = cnt_r + 5'h01;
            end
        end
        // A short or long frame still latches the last 24 bits shifted.
        if (le_rise) begin
            last_cnt_nxt = cnt_r;
            if (shift_r[`HVSL_SELECT_BIT]) begin
                dat_nxt = shift_r[`HVSL_OUTPUT_SELECT_BITS_MSB:`HVSL_OUTPUT_SELECT_BITS_LSB];
            end else begin
                cfg_nxt = shift_r;
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            shift_r <= `HVSL_WORD_RESET;
            cnt_r <= '0;
            cfg_r <= `HVSL_WORD_RESET;
            dat_r <= `HVSL_OUT_RESET;
            last_cnt_r <= '0;
        end else begin
            shift_r <= shift_nxt;
            cnt_r <= cnt_nxt;
            cfg_r <= cfg_nxt;
            dat_r <= dat_nxt;
            last_cnt_r <= last_cnt_nxt;
        end
    end

    // ---------------------------------------------------------------
    // Output drive
    // ---------------------------------------------------------------
    logic allow_r;
    hvsl_pkg::hvsl_out_type out_nxt;
    logic [2:0] vsel_nxt;

    always_comb begin
        out_nxt = `HVSL_OUT_RESET;
        if (gate_s && allow_r) begin
            out_nxt = dat_r;
        end
        vsel_nxt = cfg_r[`HVSL_VSEL_MSB:`HVSL_VSEL_LSB];
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_output_select_bits <= `HVSL_OUT_RESET;
            o_boost_vsel <= 3'h0;
            o_current_cap_field <= 2'h0;
            o_current_cap_disable <= 1'b0;
            o_sync_enable <= 1'b0;
            o_soft_start_off <= 1'b0;
        end else begin
            o_output_select_bits <= out_nxt;
            o_boost_vsel <= vsel_nxt;
            o_current_cap_field <= cfg_r[`HVSL_CAP_MSB:`HVSL_CAP_LSB];
            o_current_cap_disable <= cfg_r[`HVSL_CAPDIS_BIT];
            o_sync_enable <= cfg_r[`HVSL_SYNC_BIT];
            o_soft_start_off <= cfg_r[`HVSL_SSOFF_BIT];
        end
    end

    // ---------------------------------------------------------------
    // Wishbone register window
    // ---------------------------------------------------------------
    // Every access, mapped or not, gets one ack; unmapped reads return zero.
    logic err_r;
    logic err_nxt;
    logic allow_nxt;
    logic ack_nxt;
    logic [31:0] rdat_nxt;
    logic wb_req;
    logic [1:0] wb_idx;

    assign wb_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
    assign wb_idx = i_wb_adr[3:2];

    always_comb begin
        allow_nxt = allow_r;
        err_nxt = err_r;
        ack_nxt = wb_req;
        rdat_nxt = 32'h0000_0000;
        if (wb_req && i_wb_we && i_wb_sel[0]) begin
            if (wb_idx == `HVSL_ADR_CTRL) begin
                allow_nxt = i_wb_dat[`HVSL_CTRL_ALLOW_BIT];
            end
            if (wb_idx == `HVSL_ADR_STAT && i_wb_dat[`HVSL_STAT_ERR_BIT]) begin
                err_nxt = 1'b0;
            end
        end
        // Setting beats clearing so a bad frame is never lost.
        if (le_rise && cnt_r != `HVSL_BITS_PER_WORD) begin
            err_nxt = 1'b1;
        end
        if (wb_req && !i_wb_we) begin
            case (wb_idx)
                `HVSL_ADR_CTRL: rdat_nxt[`HVSL_CTRL_ALLOW_BIT] = allow_r;
                `HVSL_ADR_CFG: rdat_nxt[`HVSL_WORD_W-1:0] = cfg_r;
                `HVSL_ADR_DATA: begin
                    rdat_nxt[`HVSL_OUTPUT_SELECT_BITS_MSB:`HVSL_OUTPUT_SELECT_BITS_LSB] = dat_r;
                    rdat_nxt[`HVSL_SELECT_BIT] = 1'b1;
                end
                `HVSL_ADR_STAT: begin
                    rdat_nxt[`HVSL_STAT_ERR_BIT] = err_r;
                    rdat_nxt[`HVSL_STAT_CNT_LSB+:`HVSL_CNT_W] = last_cnt_r;
                end
                default: rdat_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            allow_r <= `HVSL_CTRL_RESET;
            err_r <= 1'b0;
            o_wb_ack <= 1'b0;
            o_wb_dat <= 32'h0000_0000;
        end else begin
            allow_r <= allow_nxt;
            err_r <= err_nxt;
            o_wb_ack <= ack_nxt;
            o_wb_dat <= rdat_nxt;
        end
    end

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    AST_SAMPLE_ON_RISE: assert property (
        @(posedge i_sys_clk) disable iff (!i_resetn)
        (sclk_rise && !le_s) |=> (shift_r[0] == $past(din_s)))
        else $error("Data bit not sampled on clock rise.");

    AST_LATCH_DATA: assert property (
        @(posedge i_sys_clk) disable iff (!i_resetn)
        (le_rise && shift_r[0]) |=> (dat_r == $past(shift_r[21:1])))
        else $error("Data word not latched on strobe rise.");

    AST_ROUTE_CFG: assert property (
        @(posedge i_sys_clk) disable iff (!i_resetn)
        (le_rise && !shift_r[0]) |=> (cfg_r == $past(shift_r)) && $stable(dat_r))
        else $error("Configuration word misrouted.");

    AST_HOLD_WHILE_SHIFT: assert property (
        @(posedge i_sys_clk) disable iff (!i_resetn)
        !le_rise |=> ($stable(dat_r) && $stable(cfg_r)))
        else $error("Latched state changed without strobe rise.");

    AST_DRIVE_SELECTED: assert property (
        @(posedge i_sys_clk) disable iff (!i_resetn)
        (gate_s && allow_r) |=> (o_output_select_bits == $past(dat_r)))
        else $error("Selected outputs not driven.");

    AST_GATE_OFF_LOW: assert property (
        @(posedge i_sys_clk) disable iff (!i_resetn)
        !gate_s |=> (o_output_select_bits == 21'h00_0000))
        else $error("Outputs not grounded with gate off.");

    AST_VSEL_FOLLOWS: assert property (
        @(posedge i_sys_clk) disable iff (!i_resetn)
        (le_rise && !shift_r[0]) |=> ##1 (o_boost_vsel == $past(shift_r[3:1], 2)))
        else $error("Voltage select does not follow configuration.");

    AST_UNUSED_ZERO: assert property (
        @(posedge i_sys_clk) disable iff (!i_resetn)
        (wb_req && !i_wb_we && wb_idx == `HVSL_ADR_DATA) |=> (o_wb_dat[31:22] == 10'h000))
        else $error("Unused data bits read nonzero.");

    AST_ACK_ONE_CYCLE: assert property (
        @(posedge i_sys_clk) disable iff (!i_resetn)
        o_wb_ack |=> !o_wb_ack)
        else $error("Bus ack held longer than one cycle.");

    AST_BAD_FRAME_FLAG: assert property (
        @(posedge i_sys_clk) disable iff (!i_resetn)
        (le_rise && cnt_r != `HVSL_BITS_PER_WORD) |=> err_r)
        else $error("Wrong-length frame not flagged.");

endmodule

// ===== hvsl_host_model.sv
// Host-side model that drives the serial latch pins.
`timescale 1ns/1ps
module hvsl_host_model (
    input wire logic i_sys_clk,
    output logic o_link_clk,
    output logic o_link_din,
    output logic o_latch_strobe,
    output logic o_output_gate,
    output logic o_boost_modulation_in
);
    // ------------------------------------------------------------
    // Boost modulation
    // ------------------------------------------------------------
    // A 500 kHz wave at 70 percent duty is 500 clock cycles, 350 of them high.
    logic mod_on = 1'b0;
    int mod_cnt = 0;
    always @(posedge i_sys_clk) begin
        mod_cnt <= (mod_cnt == 499) ? 0 : mod_cnt + 1;
        o_boost_modulation_in <= mod_on && (mod_cnt < 350);
    end
    // ------------------------------------------------------------
    // Pin sequencing
    // ------------------------------------------------------------
    int gap = 4;
    // Gate low, strobe high and a still clock before any transfer.
    initial begin
        o_link_clk = 1'b0;
        o_link_din = 1'b0;
        o_latch_strobe = 1'b1;
        o_output_gate = 1'b0;
    end
    // Four cycles a level gives a 32 ns link period; raise gap to act slowly.
    task automatic half();
        repeat (gap) @(posedge i_sys_clk);
    endtask
    task automatic set_gate(input logic g);
        @(posedge i_sys_clk);
        o_output_gate <= g;
    endtask
    task automatic start();
        half();
        o_latch_strobe <= 1'b0;
    endtask
    task automatic shift(input logic [31:0] w, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            repeat (gap / 2) @(posedge i_sys_clk);
            o_link_din <= w[i];
            repeat (gap - gap / 2) @(posedge i_sys_clk);
            o_link_clk <= 1'b1;
            half();
            o_link_clk <= 1'b0;
        end
        half();
        // The released line must not keep showing the last bit.
        o_link_din <= ~o_link_din;
    endtask
    task automatic finish();
        half();
        o_latch_strobe <= 1'b1;
        half();
    endtask
endmodule

// ===== tb_hvsl_serial_latch.sv
// Self-checking bench for the serial output latch.
`timescale 1ns/1ps
module tb_hvsl_serial_latch;
    // ------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------
    logic i_sys_clk = 1'b0;
    logic i_resetn = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0000_0000;
    logic [31:0] rdat;
    logic [31:0] rd;
    logic ack, lclk, ldin, lstb, gate, capd, sync, ssoff;
    logic [20:0] outs;
    logic [2:0] vsel;
    logic [1:0] cap;
    int n_mismatch = 0;
    int cmp_count = 0;
    always #2 i_sys_clk = ~i_sys_clk;
    hvsl_host_model host (.i_sys_clk(i_sys_clk), .o_link_clk(lclk), .o_link_din(ldin),
        .o_latch_strobe(lstb), .o_output_gate(gate), .o_boost_modulation_in());
    hvsl_serial_latch uut (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_link_clk(lclk),
        .i_link_din(ldin), .i_latch_strobe(lstb), .i_output_gate(gate), .i_wb_cyc(cyc),
        .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
        .o_wb_dat(rdat), .o_wb_ack(ack), .o_output_select_bits(outs), .o_boost_vsel(vsel),
        .o_current_cap_field(cap), .o_current_cap_disable(capd), .o_sync_enable(sync),
        .o_soft_start_off(ssoff));
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Classic cycle; the wait on ack is bounded so a dead slave ends the run.
    task automatic wb(input logic w, input logic [3:0] a, input logic [3:0] s,
        input logic [31:0] d);
        @(posedge i_sys_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        wdat <= d;
        for (int i = 0; i < 20 && ack !== 1'b1; i++) @(posedge i_sys_clk);
        if (ack !== 1'b1) begin
            n_mismatch++;
            stop_test();
        end
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    function automatic logic [31:0] cfgo();
        return {23'h0, capd, sync, ssoff, cap, vsel, 1'b0};
    endfunction
    task automatic send(input logic [31:0] w, input int n);
        host.start();
        host.shift(w, n);
        host.finish();
        repeat (10) @(posedge i_sys_clk);
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        chk({11'h0, outs}, 32'h0);
        chk(cfgo(), 32'h0);
        wb(1'b0, 4'h0, 4'hF, 32'h0);
        chk(rd, 32'h0000_0001);
        wb(1'b0, 4'hC, 4'hF, 32'h0);
        chk(rd, 32'h0);
    endtask
    // A second reset mid-run must clear state without faking a strobe edge.
    task automatic t_reset_mid();
        @(posedge i_sys_clk);
        i_resetn <= 1'b0;
        repeat (4) @(posedge i_sys_clk);
        chk(cfgo(), 32'h0);
        i_resetn <= 1'b1;
        repeat (4) @(posedge i_sys_clk);
        wb(1'b0, 4'hC, 4'hF, 32'h0);
        chk(rd, 32'h0);
        repeat (8) @(posedge i_sys_clk);
        chk({11'h0, outs}, 32'h0);
    endtask
    task automatic t_config();
        logic [31:0] w;
        send(32'h0, 24);
        chk(cfgo(), 32'h0);
        host.mod_on <= 1'b1;
        for (int v = 0; v < 8; v++) begin
            w = 32'(32'h00A5_0000 | v << 1 | (v & 3) << 4 | (v >> 1) << 6 | (v & 1) << 8);
            send(w, 24);
            chk(cfgo(), w & 32'h0000_01FE);
            chk({11'h0, outs}, 32'h0);
            wb(1'b0, 4'h8, 4'hF, 32'h0);
            chk(rd, 32'h0000_0001);
            wb(1'b0, 4'h4, 4'hF, 32'h0);
            chk(rd, w);
        end
    endtask
    task automatic t_data();
        send(32'h00EA_B54B, 24);
        chk({11'h0, outs}, 32'h0);
        chk(cfgo(), 32'h0000_01FE);
        wb(1'b0, 4'h8, 4'hF, 32'h0);
        chk(rd, 32'h002A_B54B);
        host.set_gate(1'b1);
        repeat (10) @(posedge i_sys_clk);
        chk({11'h0, outs}, 32'h0015_5AA5);
        wb(1'b1, 4'h0, 4'hF, 32'h0);
        repeat (10) @(posedge i_sys_clk);
        chk({11'h0, outs}, 32'h0);
        wb(1'b1, 4'h0, 4'hF, 32'h1);
    endtask
    // A slow host stops mid-frame; the old word must stay in force.
    task automatic t_midframe();
        host.gap = 8;
        host.start();
        host.shift(32'h0000_00F0, 12);
        chk({11'h0, outs}, 32'h0015_5AA5);
        host.shift(32'h0000_0F0F, 12);
        chk({11'h0, outs}, 32'h0015_5AA5);
        host.finish();
        repeat (10) @(posedge i_sys_clk);
        chk({11'h0, outs}, 32'h0007_8787);
        host.gap = 4;
    endtask
    task automatic t_error();
        send(32'h0100_0006, 25);
        chk(cfgo(), 32'h0000_0006);
        chk({11'h0, outs}, 32'h0007_8787);
        wb(1'b0, 4'hC, 4'hF, 32'h0);
        chk(rd, 32'h0000_1901);
        wb(1'b1, 4'hC, 4'hE, 32'h1);
        wb(1'b0, 4'hC, 4'hF, 32'h0);
        chk(rd, 32'h0000_1901);
        wb(1'b1, 4'hC, 4'hF, 32'h1);
        wb(1'b0, 4'hC, 4'hF, 32'h0);
        chk(rd, 32'h0000_1900);
    endtask
    initial begin
        repeat (16) @(posedge i_sys_clk);
        i_resetn <= 1'b1;
        repeat (4) @(posedge i_sys_clk);
        t_reset();
        t_config();
        t_data();
        t_midframe();
        t_error();
        send(32'h0, 24);
        host.mod_on <= 1'b0;
        chk(cfgo(), 32'h0);
        t_reset_mid();
        stop_test();
    end
endmodule
